// ===== apms_pkg.sv
// Notes on behaviour
// - Auto shutdown powers all down after conversion
// - Control register survives any power-down
// - Shutdown entry holds track-and-hold throughout
// - Start rising edge wakes, returns to track
// - Host waits 10 ms after shutdown wake
// - Host idles start line low between conversions
// - Auto standby keeps only reference powered
// - Standby holds until start rising edge wakes
// - Host waits 600 ns or 7 us
// - Full shutdown write powers down, holds
// - Full shutdown lasts until mode rewritten
// - Write of normal wakes from full shutdown
// - Host allows 10 ms after full shutdown
// - Auto modes powered while ready or converting, down after each conversion
// - Host services busy request before next end
// - Reset loads normal mode, all powered
// - Busy high from start fall to completion
package apms_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PM_W = 2;
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_AUTO_SHDN = 2'h1;
    localparam logic [1:0] PM_AUTO_STBY = 2'h2;
    localparam logic [1:0] PM_FULL_SHDN = 2'h3;
    localparam int SHDN_WAKE_MS = 10;
    localparam int STBY_EXT_WAKE_NS = 600;
    localparam int STBY_INT_WAKE_US = 7;
    localparam int SHDN_WAKE_CYC = SHDN_WAKE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int STBY_EXT_WAKE_CYC =
        (STBY_EXT_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STBY_INT_WAKE_CYC =
        (STBY_INT_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Conversion length in clock cycles
    localparam int CONV_CYC = 14;
    localparam int CNT_W = 24;
    typedef enum logic [1:0] {
        APMS_OFF = 2'h0,
        APMS_WAKING = 2'h1,
        APMS_READY = 2'h2,
        APMS_CONVERTING = 2'h3
    } apms_state_e;
endpackage : apms_pkg

// ===== apms_if.sv
`timescale 1ns/10ps
interface apms_if;
    logic conversion_start_n;
    logic wr_stb;
    logic [1:0] wr_mode;
    logic busy;
    logic track;
    logic powered;
    modport device (input conversion_start_n, input wr_stb, input wr_mode,
        output busy, output track, output powered);
    modport host (output conversion_start_n, output wr_stb,
        output wr_mode, input busy, input track, input powered);
endinterface : apms_if

// ===== apms_device.sv
`timescale 1ns/10ps
module apms_device #(
    parameter int SHDN_CYC = apms_pkg::SHDN_WAKE_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link
    apms_if.device lnk,
    // Board and status
    input wire logic ext_ref_i,
    output logic [1:0] power_mode_o,
    output logic ref_on_o
);
    import apms_pkg::*;
    apms_state_e state;
    logic [1:0] mode;
    logic cs_q;
    logic wr_q;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wake_cyc;
    logic cs_rise;
    logic cs_fall;
    logic wr_rise;
    logic conv_done;
    logic armed;
    assign cs_rise = lnk.conversion_start_n && !cs_q;
    assign cs_fall = !lnk.conversion_start_n && cs_q;
    assign wr_rise = lnk.wr_stb && !wr_q;
    assign conv_done = (state == APMS_CONVERTING) &&
        (cnt == CNT_W'(CONV_CYC - 1));
    always_comb begin
        if (mode == PM_AUTO_STBY) begin
            wake_cyc = ext_ref_i ? CNT_W'(STBY_EXT_WAKE_CYC)
                : CNT_W'(STBY_INT_WAKE_CYC);
        end else begin
            wake_cyc = CNT_W'(SHDN_CYC);
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            // Matches the idle low start line, so no false fall
            cs_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            cs_q <= lnk.conversion_start_n;
            wr_q <= lnk.wr_stb;
        end
    end
    // Hold after reset until the first start rise or wake
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            armed <= 1'b0;
        end else if (cs_rise || state == APMS_WAKING) begin
            armed <= 1'b1;
        end
    end
    // Mode only changes by write; power state never touches it
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mode <= PM_NORMAL;
        end else if (wr_rise) begin
            mode <= lnk.wr_mode;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= APMS_READY;
            cnt <= '0;
        end else if (wr_rise && lnk.wr_mode == PM_FULL_SHDN) begin
            state <= APMS_OFF;
            cnt <= '0;
        end else if (wr_rise && state == APMS_OFF &&
            lnk.wr_mode == PM_NORMAL) begin
            state <= APMS_WAKING;
            cnt <= '0;
        end else begin
            case (state)
                APMS_OFF: begin
                    // Full shutdown ignores the start line
                    if (cs_rise && mode != PM_FULL_SHDN) begin
                        state <= APMS_WAKING;
                        cnt <= '0;
                    end
                end
                APMS_WAKING: begin
                    if (cnt >= wake_cyc - CNT_W'(1)) begin
                        state <= APMS_READY;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                    // Early start still converts; data may be invalid
                    if (cs_fall) begin
                        state <= APMS_CONVERTING;
                        cnt <= '0;
                    end
                end
                APMS_READY: begin
                    if (cs_fall) begin
                        state <= APMS_CONVERTING;
                        cnt <= '0;
                    end
                end
                APMS_CONVERTING: begin
                    if (conv_done) begin
                        cnt <= '0;
                        if (mode == PM_AUTO_SHDN ||
                            mode == PM_AUTO_STBY) begin
                            state <= APMS_OFF;
                        end else begin
                            state <= APMS_READY;
                        end
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
                default: state <= APMS_READY;
            endcase
        end
    end
    // Outputs registered from the current state, so they show it one cycle late
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            lnk.busy <= 1'b0;
            lnk.track <= 1'b0;
            lnk.powered <= 1'b1;
            ref_on_o <= 1'b1;
            power_mode_o <= PM_NORMAL;
        end else begin
            lnk.busy <= (state == APMS_CONVERTING) && !conv_done;
            // Hold whenever off or converting
            lnk.track <= (state == APMS_WAKING) ||
                (state == APMS_READY && armed);
            lnk.powered <= (state == APMS_READY) ||
                (state == APMS_CONVERTING);
            ref_on_o <= (state != APMS_OFF) || (mode == PM_AUTO_STBY);
            power_mode_o <= mode;
        end
    end
endmodule : apms_device

// ===== apms_host.sv
`timescale 1ns/10ps
module apms_host #(
    parameter int SHDN_CYC = apms_pkg::SHDN_WAKE_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link
    apms_if.host lnk,
    // User side
    input wire logic conv_req_i,
    input wire logic mode_req_i,
    input wire logic [1:0] mode_i,
    input wire logic ext_ref_i,
    output logic done_o,
    output logic ready_o
);
    import apms_pkg::*;
    logic [CNT_W-1:0] wait_cnt;
    logic [1:0] cur_mode;
    logic busy_q;
    logic stb_phase;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            lnk.conversion_start_n <= 1'b0;
            lnk.wr_stb <= 1'b0;
            lnk.wr_mode <= PM_NORMAL;
            cur_mode <= PM_NORMAL;
            wait_cnt <= '0;
            stb_phase <= 1'b0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
            ready_o <= 1'b0;
        end else begin
            busy_q <= lnk.busy;
            // Busy fall raises done_o one cycle later, before next conversion
            done_o <= busy_q && !lnk.busy;
            lnk.wr_stb <= 1'b0;
            if (wait_cnt != '0) begin
                wait_cnt <= wait_cnt - CNT_W'(1);
            end
            if (stb_phase) begin
                // Second half of a conversion pulse: fall starts it
                lnk.conversion_start_n <= 1'b0;
                stb_phase <= 1'b0;
            end
            ready_o <= (wait_cnt == '0) && !lnk.busy && !stb_phase;
            if (mode_req_i && wait_cnt == '0 && !lnk.busy) begin
                lnk.wr_mode <= mode_i;
                lnk.wr_stb <= 1'b1;
                cur_mode <= mode_i;
                if (cur_mode == PM_FULL_SHDN && mode_i == PM_NORMAL) begin
                    wait_cnt <= CNT_W'(SHDN_CYC);
                end
                ready_o <= 1'b0;
            end else if (conv_req_i && wait_cnt == '0 && !lnk.busy &&
                !stb_phase) begin
                // Rise wakes auto modes; wait, then fall converts
                lnk.conversion_start_n <= 1'b1;
                ready_o <= 1'b0;
                if (cur_mode == PM_AUTO_SHDN) begin
                    wait_cnt <= CNT_W'(SHDN_CYC);
                    stb_phase <= 1'b1;
                end else if (cur_mode == PM_AUTO_STBY) begin
                    wait_cnt <= ext_ref_i ? CNT_W'(STBY_EXT_WAKE_CYC)
                        : CNT_W'(STBY_INT_WAKE_CYC);
                    stb_phase <= 1'b1;
                end else begin
                    stb_phase <= 1'b1;
                end
            end
            if (stb_phase && wait_cnt > CNT_W'(1)) begin
                stb_phase <= 1'b1;
                lnk.conversion_start_n <= 1'b1;
            end
        end
    end
endmodule : apms_host

// ===== apms_monitor.sv
`timescale 1ns/10ps
module apms_monitor #(
    parameter int SHDN_CYC = apms_pkg::SHDN_WAKE_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Link
    input wire logic conversion_start_n,
    input wire logic wr_stb,
    input wire logic [1:0] wr_mode,
    input wire logic busy,
    input wire logic track,
    input wire logic powered
);
    import apms_pkg::*;
    logic [1:0] mode;
    logic [4:0] bcnt;
    int ocnt;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) mode <= PM_NORMAL;
        else if ($rose(wr_stb)) mode <= wr_mode;
    end
    always_ff @(posedge sys_clk_i) begin
        bcnt <= busy ? bcnt + 5'h1 : 5'h0;
    end
    // Cycles since the last start rise, to time each auto-mode wake
    always_ff @(posedge sys_clk_i) begin
        ocnt <= $rose(conversion_start_n) ? 0 : ocnt + 1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence s_go;
        $fell(conversion_start_n) && powered && !busy;
    endsequence
    sequence s_wake;
        $rose(conversion_start_n) && !powered && mode != PM_FULL_SHDN;
    endsequence
    a_busy_rise: assert property (s_go |-> ##[1:3] busy)
        else $error("busy late");
    // Busy drops on the completing cycle, one short of the count
    a_busy_len: assert property ($fell(busy) |->
        bcnt == 5'(CONV_CYC - 1)) else $error("busy length");
    a_hold_conv: assert property (busy |-> !track)
        else $error("track in conversion");
    a_auto_down: assert property ($fell(busy) && mode != PM_NORMAL
        |-> ##[0:2] (!powered && !track)) else $error("auto not down");
    // Strobe cycle left out: the device may act on that edge
    a_normal_on: assert property (mode == PM_NORMAL && !wr_stb && powered
        |=> powered) else $error("normal lost power");
    a_full_off: assert property ($rose(wr_stb) && wr_mode == PM_FULL_SHDN
        |-> ##[1:2] (!powered && !track)) else $error("full not off");
    a_full_stay: assert property (mode == PM_FULL_SHDN && !wr_stb
        && !powered |=> !powered && !track) else $error("full woke");
    a_wake_track: assert property (s_wake |-> ##[1:3] track)
        else $error("wake no track");
    a_shdn_wait: assert property ($rose(powered) && mode == PM_AUTO_SHDN
        |-> ocnt >= SHDN_CYC) else $error("shutdown wake short");
    a_stby_wait: assert property ($rose(powered) && mode == PM_AUTO_STBY
        |-> ocnt >= STBY_EXT_WAKE_CYC) else $error("standby wake short");
    a_reset_mode: assert property ($fell(srst_i) |-> powered && !busy)
        else $error("reset state");
endmodule : apms_monitor

// ===== tb_adc_power_mode_sequencer.sv
`timescale 1ns/10ps
module tb_adc_power_mode_sequencer;
    import apms_pkg::*;
    localparam int SC = 20;
    logic sys_clk_i = 0;
    logic srst_i = 1;
    logic conv_req_i = 0, mode_req_i = 0, ext_ref_i = 0;
    logic [1:0] mode_i = 2'h0;
    logic [1:0] power_mode_o;
    logic ref_on_o, done_o, ready_o;
    int miscompares = 0;
    int total_checks = 0;
    int m = 0;
    apms_if lnk();
    apms_device #(.SHDN_CYC(SC)) apms_device_inst (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .lnk(lnk), .ext_ref_i(ext_ref_i),
        .power_mode_o(power_mode_o), .ref_on_o(ref_on_o));
    apms_host #(.SHDN_CYC(SC)) apms_host_inst (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .lnk(lnk), .conv_req_i(conv_req_i),
        .mode_req_i(mode_req_i), .mode_i(mode_i), .ext_ref_i(ext_ref_i),
        .done_o(done_o), .ready_o(ready_o));
    apms_monitor #(.SHDN_CYC(SC)) apms_monitor_inst (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .conversion_start_n(lnk.conversion_start_n),
        .wr_stb(lnk.wr_stb), .wr_mode(lnk.wr_mode), .busy(lnk.busy),
        .track(lnk.track), .powered(lnk.powered));
    always #50 sys_clk_i = ~sys_clk_i;
    task chk(input logic [1:0] s, input logic [1:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d errors %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task wt(input bit d);
        int i;
        for (i = 0; i < 400 && (d ? done_o : ready_o) !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (i == 400) begin
            miscompares++;
            report_and_stop;
        end
    endtask : wt
    task wr(input logic [1:0] v);
        wt(0);
        @(posedge sys_clk_i);
        mode_i <= v;
        mode_req_i <= 1'b1;
        @(posedge sys_clk_i);
        mode_req_i <= 1'b0;
        m = v;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk(power_mode_o, 2'(m));
    endtask : wr
    // Back-to-back calls give the wake path a second pass
    task cv;
        wt(0);
        @(posedge sys_clk_i);
        conv_req_i <= 1'b1;
        @(posedge sys_clk_i);
        conv_req_i <= 1'b0;
        #1;
        wt(1);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(lnk.powered, m == 0);
        chk(lnk.track, m == 0);
        chk(ref_on_o, m == 0 || m == 2);
        chk(power_mode_o, 2'(m));
    endtask : cv
    initial begin
        void'($urandom(32'hE23B));
        repeat (8) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        chk(power_mode_o, PM_NORMAL);
        chk(lnk.powered, 1'b1);
        cv;
        // Full shutdown entered from a powered state
        wr(PM_FULL_SHDN);
        chk(lnk.powered, 1'b0);
        chk(lnk.track, 1'b0);
        // A start pulse must not wake full shutdown
        @(posedge sys_clk_i);
        conv_req_i <= 1'b1;
        @(posedge sys_clk_i);
        conv_req_i <= 1'b0;
        repeat (30) @(posedge sys_clk_i);
        #1;
        chk(lnk.powered, 1'b0);
        chk(lnk.track, 1'b0);
        wr(PM_NORMAL);
        chk(lnk.track, 1'b1);
        repeat (SC + 4) @(posedge sys_clk_i);
        #1;
        chk(lnk.powered, 1'b1);
        cv;
        for (int k = 1; k < 3; k++) begin
            @(posedge sys_clk_i);
            ext_ref_i <= 1'($urandom);
            wr(k[1:0]);
            cv;
            cv;
        end
        report_and_stop;
    end
endmodule : tb_adc_power_mode_sequencer
